// ### include/input_decoder_pkg.sv
// Package for the input terminal function decoder.
// Assumes one 25 MHz drive clock and an APB master for configuration.
package input_decoder_pkg;

    localparam int NUM_TERM = 6;
    localparam int NUM_PROG = 4;
    localparam int FSEL_W = 5;
    localparam int ACT_W = 23;

    // Function codes
    localparam logic [4:0] FN_NONE = 5'h00;
    localparam logic [4:0] FN_FWD_RUN = 5'h01;
    localparam logic [4:0] FN_REV_RUN = 5'h02;
    localparam logic [4:0] FN_THREE_WIRE = 5'h03;
    localparam logic [4:0] FN_JOG_FWD = 5'h04;
    localparam logic [4:0] FN_JOG_REV = 5'h05;
    localparam logic [4:0] FN_COAST = 5'h06;
    localparam logic [4:0] FN_FAULT_RESET = 5'h07;
    localparam logic [4:0] FN_RUN_PAUSE = 5'h08;
    localparam logic [4:0] FN_EXT_FAULT = 5'h09;
    localparam logic [4:0] FN_FREQ_UP = 5'h0a;
    localparam logic [4:0] FN_FREQ_DOWN = 5'h0b;
    localparam logic [4:0] FN_AUX_CLEAR = 5'h0c;
    localparam logic [4:0] FN_SW_A_B = 5'h0d;
    localparam logic [4:0] FN_SW_COMB_A = 5'h0e;
    localparam logic [4:0] FN_SW_COMB_B = 5'h0f;
    localparam logic [4:0] FN_STEP0 = 5'h10;
    localparam logic [4:0] FN_STEP_PAUSE = 5'h14;
    localparam logic [4:0] FN_RAMP_SEL0 = 5'h15;
    localparam logic [4:0] FN_RAMP_SEL1 = 5'h16;

    // Register byte offsets
    localparam logic [7:0] FSEL_BASE_OFS = 8'h00;
    localparam logic [7:0] HDI_MODE_OFS = 8'h18;
    localparam logic [7:0] ACTIVE_OFS = 8'h1c;
    localparam logic [7:0] LEVELS_OFS = 8'h20;

    // Reset values
    localparam logic [4:0] FSEL_RST = 5'h00;
    localparam logic [1:0] HDI_MODE_RST = 2'h0;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_s;

    typedef struct packed {
        logic forward_run_request;
        logic reverse_run_request;
        logic three_wire_mode;
        logic three_wire_input;
        logic jog_fwd;
        logic jog_rev;
        logic coast_stop;
        logic fault_reset_pulse;
        logic run_pause;
        logic ext_fault_alarm;
        logic freq_up;
        logic freq_down;
        logic aux_clear;
        logic sel_chan_b;
        logic sel_comb_a;
        logic sel_comb_b;
        logic [3:0] step_index;
        logic [1:0] ramp_group;
    } drive_cmd_s;

endpackage : input_decoder_pkg

// ### design/input_terminal_function_decoder.sv
// Terminal function decoder with APB configuration registers.
// Assumes terminal pins are asynchronous and the APB master is on ref_clk.
//
// Function
// (R01) Four programmable terminals and two high-speed terminals each get a function code.
// (R02) Each high-speed terminal is either pulse input or ordinary decoded digital input.
// (R03) Software must not give one function code to two terminals.
// (R04) Code 0 terminals are ignored completely.
// (R05) Codes 1 and 2 request forward and reverse running.
// (R06) Code 3 selects three-wire mode, terminal is the three-wire input.
// (R07) Codes 4 and 5 request forward and reverse jogging.
// (R08) Code 6 blocks output at once, motor coasts.
// (R09) Code 7 produces a fault-reset request like the keypad reset key.
// (R10) Code 8 pauses running, state kept, resumes when removed.
// (R11) Code 9 raises an external fault alarm and stops the drive.
// (R12) Codes 10 and 11 step the terminal frequency up and down.
// (R13) Code 12 clears the up/down auxiliary frequency value.
// (R14) Code 13 switches frequency reference between channel A and B.
// (R15) Codes 14 and 15 switch combination channel against A or B.
// (R16) Codes 16 to 19 form the 4-bit step speed index, 16 first.
// (R17) Code 20 freezes the step index while asserted.
// (R18) Code 21 is ramp group select bit 0, one of four groups.
// (R19) Code 22 is ramp select bit 1; both off is group 1.
// (R20) Terminals are synchronised on the clock; closed means active.
module input_terminal_function_decoder
    import input_decoder_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // APB slave
    input wire apb_req_s apb_in,
    output apb_rsp_s apb_out,
    // Terminal pins, closed is high
    input wire logic [NUM_TERM-1:0] terminal_in,
    // Decoded commands and pulse-mode terminal levels
    output drive_cmd_s cmd_out,
    output logic [1:0] hs_pulse_out
);

    typedef struct packed {
        logic [NUM_TERM-1:0] sync1;
        logic [NUM_TERM-1:0] sync2;
        logic [NUM_TERM-1:0][FSEL_W-1:0] fsel;
        logic [1:0] hdi_digital;
        logic [ACT_W-1:0] act;
        logic [1:0] pulse;
        drive_cmd_s cmd;
        apb_rsp_s rsp;
    } state_s;

    state_s state_reg;
    state_s state_next;

    // One-hot OR of the functions driven by closed, enabled terminals
    function automatic logic [31:0] decode_active(
        input logic [NUM_TERM-1:0][FSEL_W-1:0] sel,
        input logic [NUM_TERM-1:0] closed,
        input logic [NUM_TERM-1:0] enabled
    );
        logic [31:0] v;
        v = 32'h0;
        for (int i = 0; i < NUM_TERM; i++) begin
            if (closed[i] && enabled[i]) begin
                v[sel[i]] = 1'b1; // [R20]
            end
        end
        v[FN_NONE] = 1'b0; // [R04]
        return v;
    endfunction

    // Any enabled terminal carrying a given code, regardless of level
    function automatic logic code_assigned(
        input logic [NUM_TERM-1:0][FSEL_W-1:0] sel,
        input logic [NUM_TERM-1:0] enabled,
        input logic [4:0] code
    );
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < NUM_TERM; i++) begin
            if (enabled[i] && sel[i] == code) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    logic [NUM_TERM-1:0] term_en;
    logic [31:0] act_full;
    logic [ACT_W-1:0] act_c;
    logic setup_c;
    logic access_c;
    logic [7:0] addr_c;
    logic fsel_hit_c;
    logic [2:0] fsel_idx_c;
    logic fault_pulse_c;

    always_comb begin
        state_next = state_reg;
        // Programmable terminals always decode; high-speed ones by mode
        term_en = {state_reg.hdi_digital, {NUM_PROG{1'b1}}}; // [R01] [R02]
        act_full = decode_active(state_reg.fsel, state_reg.sync2, term_en);
        act_c = act_full[ACT_W-1:0];
        addr_c = apb_in.paddr;
        setup_c = apb_in.psel && !apb_in.penable;
        access_c = apb_in.psel && apb_in.penable && state_reg.rsp.pready;
        fsel_hit_c = (addr_c[1:0] == 2'h0) &&
            (addr_c < FSEL_BASE_OFS + 8'(NUM_TERM * 4));
        fsel_idx_c = addr_c[4:2];

        // Two-flop synchroniser; sync1 feeds only sync2
        state_next.sync1 = terminal_in; // [R20]
        state_next.sync2 = state_reg.sync1;
        state_next.act = act_c;

        // Pulse-mode terminals bypass decoding entirely
        state_next.pulse = state_reg.sync2[5:4] & ~state_reg.hdi_digital; // [R02]

        state_next.cmd.forward_run_request = act_c[FN_FWD_RUN]; // [R05]
        state_next.cmd.reverse_run_request = act_c[FN_REV_RUN]; // [R05]
        state_next.cmd.three_wire_mode =
            code_assigned(state_reg.fsel, term_en, FN_THREE_WIRE); // [R06]
        state_next.cmd.three_wire_input = act_c[FN_THREE_WIRE]; // [R06]
        state_next.cmd.jog_fwd = act_c[FN_JOG_FWD]; // [R07]
        state_next.cmd.jog_rev = act_c[FN_JOG_REV]; // [R07]
        state_next.cmd.coast_stop = act_c[FN_COAST]; // [R08]
        state_next.cmd.run_pause = act_c[FN_RUN_PAUSE]; // [R10]
        state_next.cmd.freq_up = act_c[FN_FREQ_UP]; // [R12]
        state_next.cmd.freq_down = act_c[FN_FREQ_DOWN]; // [R12]
        state_next.cmd.aux_clear = act_c[FN_AUX_CLEAR]; // [R13]
        state_next.cmd.sel_chan_b = act_c[FN_SW_A_B]; // [R14]
        state_next.cmd.sel_comb_a = act_c[FN_SW_COMB_A]; // [R15]
        state_next.cmd.sel_comb_b = act_c[FN_SW_COMB_B]; // [R15]

        // Reset request fires once per closing, like a key press
        fault_pulse_c = act_c[FN_FAULT_RESET] &&
            !state_reg.act[FN_FAULT_RESET]; // [R09]
        state_next.cmd.fault_reset_pulse = fault_pulse_c;
        // Alarm latches; a live fault input wins over a reset
        state_next.cmd.ext_fault_alarm = act_c[FN_EXT_FAULT] ||
            (state_reg.cmd.ext_fault_alarm && !fault_pulse_c); // [R11]

        // Freeze holds the last index, step terminals ignored meanwhile
        if (!act_c[FN_STEP_PAUSE]) begin // [R17]
            state_next.cmd.step_index =
                act_c[FN_STEP0+3:FN_STEP0]; // [R16]
        end
        state_next.cmd.ramp_group =
            {act_c[FN_RAMP_SEL1], act_c[FN_RAMP_SEL0]}; // [R18] [R19]

        // APB: answer prepared in setup, ready for one access cycle
        state_next.rsp.pready = setup_c;
        if (setup_c) begin
            state_next.rsp.pslverr = 1'b0;
            state_next.rsp.prdata = 32'h0;
            if (fsel_hit_c) begin
                state_next.rsp.prdata =
                    {27'h0, state_reg.fsel[fsel_idx_c]}; // [R01]
            end else if (addr_c == HDI_MODE_OFS) begin
                state_next.rsp.prdata = {30'h0, state_reg.hdi_digital};
            end else if (addr_c == ACTIVE_OFS) begin
                state_next.rsp.prdata = {9'h0, state_reg.act};
            end else if (addr_c == LEVELS_OFS) begin
                state_next.rsp.prdata = {26'h0, state_reg.sync2};
            end else begin
                state_next.rsp.pslverr = 1'b1;
            end
        end
        if (access_c && apb_in.pwrite && !state_reg.rsp.pslverr) begin
            if (fsel_hit_c) begin
                state_next.fsel[fsel_idx_c] = apb_in.pwdata[FSEL_W-1:0];
            end else if (addr_c == HDI_MODE_OFS) begin
                state_next.hdi_digital = apb_in.pwdata[1:0]; // [R02]
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            state_reg <= '0;
            state_reg.fsel <= {NUM_TERM{FSEL_RST}};
            state_reg.hdi_digital <= HDI_MODE_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    assign apb_out = state_reg.rsp;
    assign cmd_out = state_reg.cmd;
    assign hs_pulse_out = state_reg.pulse;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);

    // Code 0 on every terminal leaves forward run, coast stop and fault alarm idle
    property p_code_zero_idle;
        (state_reg.fsel == '0) [*3] |->
            !cmd_out.forward_run_request && !cmd_out.coast_stop &&
            !cmd_out.ext_fault_alarm;
    endproperty
    a_code_zero_idle: assert property (p_code_zero_idle) // [R04]
        else $error("code 0 terminal caused an action");

    property p_pin_to_forward;
        (state_reg.fsel[0] == FN_FWD_RUN && terminal_in[0]) [*4] |->
            cmd_out.forward_run_request;
    endproperty
    a_pin_to_forward: assert property (p_pin_to_forward) // [R05]
        else $error("closed forward terminal not seen in three cycles");

    property p_coast;
        (state_reg.fsel[0] == FN_COAST && terminal_in[0]) [*4] |->
            cmd_out.coast_stop;
    endproperty
    a_coast: assert property (p_coast) // [R08]
        else $error("coast stop not following its terminal");

    property p_reset_single;
        cmd_out.fault_reset_pulse |=> !cmd_out.fault_reset_pulse;
    endproperty
    a_reset_single: assert property (p_reset_single) // [R09]
        else $error("fault reset request longer than one cycle");

    property p_fault_alarm;
        state_reg.act[FN_EXT_FAULT] |=> cmd_out.ext_fault_alarm;
    endproperty
    a_fault_alarm: assert property (p_fault_alarm) // [R11]
        else $error("external fault did not raise alarm");

    property p_alarm_holds;
        $fell(cmd_out.ext_fault_alarm) |-> cmd_out.fault_reset_pulse;
    endproperty
    a_alarm_holds: assert property (p_alarm_holds) // [R11]
        else $error("fault alarm dropped without reset");

    property p_step_freeze;
        state_reg.act[FN_STEP_PAUSE] |-> $stable(cmd_out.step_index);
    endproperty
    a_step_freeze: assert property (p_step_freeze) // [R17]
        else $error("step index changed while frozen");

    property p_ramp_group;
        (state_reg.fsel[0] == FN_RAMP_SEL1 && terminal_in[0]) [*4] |->
            cmd_out.ramp_group[1];
    endproperty
    a_ramp_group: assert property (p_ramp_group) // [R19]
        else $error("ramp group not matching select terminals");

    property p_pulse_mode;
        !state_reg.hdi_digital[0] && $past(!state_reg.hdi_digital[0]) |->
            !state_reg.act[state_reg.fsel[4]] || state_reg.fsel[4] == 5'h0 ||
            code_assigned(state_reg.fsel, 6'h0f, state_reg.fsel[4]) ||
            $past(state_reg.fsel) != state_reg.fsel;
    endproperty
    a_pulse_mode: assert property (p_pulse_mode) // [R02]
        else $error("pulse-mode terminal took part in decoding");

    // Pin-path checks allow two sync edges plus the decode edge
    property p_pin_to_reverse;
        (state_reg.fsel[0] == FN_REV_RUN && terminal_in[0]) [*4] |->
            cmd_out.reverse_run_request;
    endproperty
    a_pin_to_reverse: assert property (p_pin_to_reverse) // [R05]
        else $error("closed reverse terminal not seen");

    // Mode follows the assignment alone, whatever the pin level
    property p_three_wire_mode;
        (state_reg.fsel[0] == FN_THREE_WIRE) [*2] |->
            cmd_out.three_wire_mode;
    endproperty
    a_three_wire_mode: assert property (p_three_wire_mode) // [R06]
        else $error("three-wire mode not set by its code");

    property p_jog_fwd;
        (state_reg.fsel[0] == FN_JOG_FWD && terminal_in[0]) [*4] |->
            cmd_out.jog_fwd;
    endproperty
    a_jog_fwd: assert property (p_jog_fwd) // [R07]
        else $error("closed jog terminal not seen");

    // A lingering pause would keep the drive from resuming
    property p_pause_release;
        (state_reg.fsel[0] == FN_RUN_PAUSE && !terminal_in[0]) [*4] |->
            !cmd_out.run_pause;
    endproperty
    a_pause_release: assert property (p_pause_release) // [R10]
        else $error("running pause held after its terminal opened");

    property p_freq_down;
        (state_reg.fsel[0] == FN_FREQ_DOWN && terminal_in[0]) [*4] |->
            cmd_out.freq_down;
    endproperty
    a_freq_down: assert property (p_freq_down) // [R12]
        else $error("closed frequency-down terminal not seen");

    property p_aux_clear;
        (state_reg.fsel[0] == FN_AUX_CLEAR && terminal_in[0]) [*4] |->
            cmd_out.aux_clear;
    endproperty
    a_aux_clear: assert property (p_aux_clear) // [R13]
        else $error("closed auxiliary clear terminal not seen");

    property p_chan_b;
        (state_reg.fsel[0] == FN_SW_A_B && terminal_in[0]) [*4] |->
            cmd_out.sel_chan_b;
    endproperty
    a_chan_b: assert property (p_chan_b) // [R14]
        else $error("closed channel switch terminal not seen");

    property p_comb_a;
        (state_reg.fsel[0] == FN_SW_COMB_A && terminal_in[0]) [*4] |->
            cmd_out.sel_comb_a;
    endproperty
    a_comb_a: assert property (p_comb_a) // [R15]
        else $error("closed combination switch terminal not seen");

    // Only checked with no freeze terminal assigned anywhere
    property p_step_bit0;
        (state_reg.fsel[0] == FN_STEP0 && terminal_in[0] &&
            !code_assigned(state_reg.fsel, 6'h3f, FN_STEP_PAUSE)) [*4] |->
            cmd_out.step_index[0];
    endproperty
    a_step_bit0: assert property (p_step_bit0) // [R16]
        else $error("first step terminal not in index bit 0");

    property p_ramp_bit0;
        (state_reg.fsel[0] == FN_RAMP_SEL0 && terminal_in[0]) [*4] |->
            cmd_out.ramp_group[0];
    endproperty
    a_ramp_bit0: assert property (p_ramp_bit0) // [R18]
        else $error("first ramp select terminal not in group bit 0");

    // Sync stage checked once reset has been off for two edges
    property p_sync_two_flops;
        $past(rst_b_in) && $past(rst_b_in, 2) |->
            state_reg.sync2 == $past(terminal_in, 2);
    endproperty
    a_sync_two_flops: assert property (p_sync_two_flops) // [R20]
        else $error("synchronised levels not two edges behind pins");

    property p_pulse_quiet;
        state_reg.hdi_digital[0] [*2] |-> !hs_pulse_out[0];
    endproperty
    a_pulse_quiet: assert property (p_pulse_quiet) // [R02]
        else $error("pulse output active on a digital-mode terminal");

    property p_apb_ready;
        apb_out.pready |=> !apb_out.pready;
    endproperty
    a_apb_ready: assert property (p_apb_ready)
        else $error("pready held beyond one cycle");

endmodule // input_terminal_function_decoder

// ### verification/terminal_switch_model.sv
// Far-side model: a bank of terminal switches or controller outputs.
// Assumes the bench commands switch states just after a rising edge.
module terminal_switch_model
    import input_decoder_pkg::*;
(
    // Clock
    input wire logic ref_clk_in,
    // Commanded switch states, 1 closes the contact
    input wire logic [NUM_TERM-1:0] close_in,
    // Pin levels seen by the drive
    output logic [NUM_TERM-1:0] terminal_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // Closed contact pulls the pin high
    // Contacts move a cycle late, like a real relay path
    always_ff @(posedge ref_clk_in) begin
        terminal_out <= close_in;
    end
endmodule // terminal_switch_model

// ### verification/testbench.sv
// Self-checking bench for the terminal function decoder.
// Assumes APB with one access cycle and three-edge pin latency.
module testbench
    import input_decoder_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [4:0] code;
        logic [21:0] on;
        logic [21:0] off;
    } row_s;
    logic ref_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    apb_req_s req = '0;
    apb_rsp_s rsp;
    drive_cmd_s cmd;
    logic [1:0] hs_pulse;
    logic [NUM_TERM-1:0] close = '0;
    logic [NUM_TERM-1:0] pins;
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic err;
    int pulses;
    row_s rows [0:20] = '{
        '{5'h00, 22'h000000, 22'h0}, '{5'h01, 22'h200000, 22'h0},
        '{5'h02, 22'h100000, 22'h0}, '{5'h03, 22'h0c0000, 22'h080000},
        '{5'h04, 22'h020000, 22'h0}, '{5'h05, 22'h010000, 22'h0},
        '{5'h06, 22'h008000, 22'h0}, '{5'h08, 22'h002000, 22'h0},
        '{5'h0a, 22'h000800, 22'h0}, '{5'h0b, 22'h000400, 22'h0},
        '{5'h0c, 22'h000200, 22'h0}, '{5'h0d, 22'h000100, 22'h0},
        '{5'h0e, 22'h000080, 22'h0}, '{5'h0f, 22'h000040, 22'h0},
        '{5'h10, 22'h000004, 22'h0}, '{5'h11, 22'h000008, 22'h0},
        '{5'h12, 22'h000010, 22'h0}, '{5'h13, 22'h000020, 22'h0},
        '{5'h15, 22'h000001, 22'h0}, '{5'h16, 22'h000002, 22'h0},
        '{5'h17, 22'h000000, 22'h0}
    };

    input_terminal_function_decoder input_terminal_function_decoder_inst (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .apb_in(req),
        .apb_out(rsp),
        .terminal_in(pins),
        .cmd_out(cmd),
        .hs_pulse_out(hs_pulse)
    );
    terminal_switch_model terminal_switch_model_inst (
        .ref_clk_in(ref_clk_in),
        .close_in(close),
        .terminal_out(pins)
    );

    initial begin
        forever #20 ref_clk_in = ~ref_clk_in;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Generous ceiling; the whole run needs under 2000 cycles
    always @(posedge ref_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail = n_fail + 1;
            tally_and_finish();
        end
    end

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_cmd(input drive_cmd_s got, input logic [21:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== drive_cmd_s'(exp)) begin
            n_fail = n_fail + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Setup, then access held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk_in);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge ref_clk_in);
        req.penable <= 1'b1;
        do @(posedge ref_clk_in); while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    // Pin path: model stage plus three edges in the decoder
    task automatic set_pins(input logic [NUM_TERM-1:0] v);
        @(posedge ref_clk_in);
        close <= v;
        repeat (6) @(negedge ref_clk_in);
    endtask

    initial begin
        repeat (12) @(posedge ref_clk_in);
        rst_b_in <= 1'b1;
        @(negedge ref_clk_in);
        check_cmd(cmd, 22'h0);
        apb(1'b0, FSEL_BASE_OFS + 8'h14, 32'h0);
        check_word(rd, 32'h0);
        apb(1'b0, HDI_MODE_OFS, 32'h0);
        check_word(rd, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        check_word({31'h0, err}, 32'h1);
        $display("test reset_and_map done");
        // Each row configures one code on terminal 0 only
        foreach (rows[i]) begin
            apb(1'b1, FSEL_BASE_OFS, {27'h0, rows[i].code});
            apb(1'b0, FSEL_BASE_OFS, 32'h0);
            check_word(rd, {27'h0, rows[i].code});
            set_pins(6'h01);
            check_cmd(cmd, rows[i].on);
            set_pins(6'h00);
            check_cmd(cmd, rows[i].off);
        end
        $display("test code_table done");
        // Terminal 4 in pulse mode decodes nothing
        apb(1'b1, FSEL_BASE_OFS, 32'h0);
        apb(1'b1, FSEL_BASE_OFS + 8'h10, 32'h1);
        set_pins(6'h10);
        check_cmd(cmd, 22'h0);
        check_word({30'h0, hs_pulse}, 32'h1);
        apb(1'b1, HDI_MODE_OFS, 32'h1);
        repeat (2) @(negedge ref_clk_in);
        check_cmd(cmd, 22'h200000);
        check_word({30'h0, hs_pulse}, 32'h0);
        $display("test high_speed_mode done");
        // Step bits on terminals 0..3, freeze on terminal 4
        for (int t = 0; t < 4; t++) begin
            apb(1'b1, FSEL_BASE_OFS + 8'(4 * t), 32'(FN_STEP0) + t);
        end
        apb(1'b1, FSEL_BASE_OFS + 8'h10, {27'h0, FN_STEP_PAUSE});
        set_pins(6'h0a);
        check_cmd(cmd, 22'h000028);
        set_pins(6'h1a);
        set_pins(6'h15);
        check_cmd(cmd, 22'h000028);
        apb(1'b0, LEVELS_OFS, 32'h0);
        check_word(rd, 32'h15);
        apb(1'b1, ACTIVE_OFS, 32'hffffffff);
        apb(1'b0, ACTIVE_OFS, 32'h0);
        check_word(rd, 32'h150000);
        set_pins(6'h05);
        check_cmd(cmd, 22'h000014);
        set_pins(6'h00);
        $display("test step_freeze done");
        // Alarm holds after the input opens, until a reset pulse
        apb(1'b1, FSEL_BASE_OFS, {27'h0, FN_EXT_FAULT});
        apb(1'b1, FSEL_BASE_OFS + 8'h04, {27'h0, FN_FAULT_RESET});
        set_pins(6'h01);
        check_cmd(cmd, 22'h001000);
        set_pins(6'h00);
        check_cmd(cmd, 22'h001000);
        @(posedge ref_clk_in);
        close <= 6'h02;
        pulses = 0;
        repeat (8) begin
            @(negedge ref_clk_in);
            if (cmd.fault_reset_pulse === 1'b1) begin
                pulses = pulses + 1;
            end
        end
        check_word(32'(pulses), 32'h1);
        check_cmd(cmd, 22'h0);
        $display("test fault_alarm done");
        // Mid-run reset with the alarm raised and its pin still closed
        set_pins(6'h01);
        check_cmd(cmd, 22'h001000);
        @(posedge ref_clk_in);
        rst_b_in <= 1'b0;
        repeat (3) @(posedge ref_clk_in);
        rst_b_in <= 1'b1;
        @(negedge ref_clk_in);
        check_cmd(cmd, 22'h0);
        apb(1'b0, FSEL_BASE_OFS, 32'h0);
        check_word(rd, {27'h0, FSEL_RST});
        check_cmd(cmd, 22'h0);
        $display("test mid_reset done");
        tally_and_finish();
    end
endmodule // testbench
